// >>> mrx_exec.sv
// Purpose: executes store, option, reset, idle and return instructions
// Assumes: instructions are issued by writing the instruction register
// Notes:   returns hold waitrequest one extra cycle for the stack pop
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module mrx_exec (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic device_reset_req,
  output logic [7:0] option_cfg,
  output logic global_irq_enable,
  output logic [14:0] pc
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mrx_pkg::mrx_state_t state, next_state;
  logic ack;
  logic [7:0] acc;
  logic [7:0] status;
  logic [15:0] indirect_pointer [2];
  logic [15:0] next_ptr [2];
  logic soft_reset_flag_n;
  logic [13:0] last_op;
  logic bad_op;
  logic [3:0] sp;
  logic [14:0] stack_mem [16];
  logic [7:0] file_mem [128];
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  wire req = avs_read | avs_write;
  wire accept = req & ack;
  wire [13:0] op = avs_writedata[13:0];
  wire instr_wr = avs_write & (avs_address == mrx_pkg::REG_INSTR);

  // one consistent encoding for the core
  wire is_idle = op == mrx_pkg::OP_IDLE;
  wire is_reset = op == mrx_pkg::OP_RESET;
  wire is_ret = op == mrx_pkg::OP_RET;
  wire is_rti = op == mrx_pkg::OP_RTI;
  wire is_option = op == mrx_pkg::OP_OPTION;
  wire is_fst = op[13:7] == mrx_pkg::OP_FST_HI;
  wire is_ist = op[13:3] == mrx_pkg::OP_IST_HI;
  wire is_rel = op[13:7] == mrx_pkg::OP_REL_HI;
  wire known = is_idle | is_reset | is_ret | is_rti | is_option | is_fst |
               is_ist | is_rel;
  wire two_cycle = instr_wr & (is_ret | is_rti);
  // the extra wait cycle stands for the stack pop of a return
  wire hold = two_cycle & (state == mrx_pkg::mrx_st_idle);
  assign avs_waitrequest = req & ~ack;
  wire exec = accept & instr_wr;
  wire do_reset = exec & is_reset;
  wire do_pop = exec & (is_ret | is_rti);

  // ---------------------------------------------------------------
  // operand decode
  // ---------------------------------------------------------------
  wire [6:0] fst_addr = op[6:0];
  wire ist_n = is_rel ? op[6] : op[2];
  wire [1:0] pointer_update_mode = op[1:0];
  wire [5:0] rel_k = op[5:0];
  wire [15:0] ptr_sel = indirect_pointer[ist_n];
  // 16-bit adders wrap modulo the pointer range
  wire [15:0] ptr_step = pointer_update_mode[0] ? 16'hffff : 16'h0001;
  wire [15:0] ptr_upd = ptr_sel + ptr_step;
  wire [15:0] rel_ea = ptr_sel + {{10{rel_k[5]}}, rel_k};
  // pre modes address the updated pointer, post modes the old one
  wire [15:0] ist_ea = is_rel ? rel_ea :
                       (pointer_update_mode[1] ? ptr_sel : ptr_upd);
  // the two lowest file addresses are the indirect data ports
  wire fst_port = fst_addr[6:1] == 6'h00;
  wire [6:0] fst_target = fst_port ?
                          indirect_pointer[fst_addr[0]][6:0] : fst_addr;
  wire [6:0] bus_idx = avs_address[8:2];
  wire bus_port = bus_idx[6:1] == 6'h00;
  wire [6:0] bus_target = bus_port ?
                          indirect_pointer[bus_idx[0]][6:0] : bus_idx;
  wire is_file = avs_address[mrx_pkg::FILE_SEL_BIT];

  wire file_we_fst = exec & is_fst;
  wire file_we_ist = exec & (is_ist | is_rel);
  wire file_we_bus = accept & avs_write & is_file;
  wire [6:0] file_waddr = file_we_fst ? fst_target :
                          (file_we_ist ? ist_ea[6:0] : bus_target);
  wire [7:0] file_wdata = (file_we_fst | file_we_ist) ? acc :
                          avs_writedata[7:0];
  // ---------------------------------------------------------------
  // byte enables
  // ---------------------------------------------------------------
  logic [31:0] be_mask;
  for (genvar b = 0; b < 4; b++) begin : g_be
    assign be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
  end
  wire [31:0] wmask = avs_writedata & be_mask;
  wire wr_go = accept & avs_write;
  wire wr_acc = wr_go & (avs_address == mrx_pkg::REG_ACC) & avs_byteenable[0];
  wire wr_pc = wr_go & (avs_address == mrx_pkg::REG_PC);
  wire wr_status = wr_go & (avs_address == mrx_pkg::REG_STATUS) &
                   avs_byteenable[0];
  wire wr_power_control_reg = wr_go & (avs_address == mrx_pkg::REG_POWER_CONTROL_REG) &
                 avs_byteenable[0];
  wire wr_irq_control_reg = wr_go & (avs_address == mrx_pkg::REG_IRQ_CONTROL_REG) &
                   avs_byteenable[0];
  wire wr_push = wr_go & (avs_address == mrx_pkg::REG_STACK);
  wire [14:0] pc_merged = (pc & ~be_mask[14:0]) | wmask[14:0];
  wire [3:0] sp_top = sp - 4'h1;
  wire [14:0] stack_top = stack_mem[sp_top];

  // ---------------------------------------------------------------
  // pointers, one per index
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    wire wr_ptr = wr_go & (avs_address == (i == 0 ? mrx_pkg::REG_PTR0 :
                                           mrx_pkg::REG_PTR1));
    wire upd = exec & is_ist & (ist_n == 1'(i));
    always_comb begin
      if (do_reset) begin
        next_ptr[i] = mrx_pkg::PTR_RST;
      end else if (wr_ptr) begin
        next_ptr[i] = (indirect_pointer[i] & ~be_mask[15:0]) | wmask[15:0];
      end else if (upd) begin
        next_ptr[i] = ptr_upd;
      end else begin
        next_ptr[i] = indirect_pointer[i]; // relative form keeps it
      end
    end
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        indirect_pointer[i] <= mrx_pkg::PTR_RST;
      end else begin
        indirect_pointer[i] <= next_ptr[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // handshake and sequencing
  // ---------------------------------------------------------------
  always_comb begin
    case (state)
      mrx_pkg::mrx_st_idle: next_state = (req & ~ack & hold) ?
                                         mrx_pkg::mrx_st_pop : state;
      mrx_pkg::mrx_st_pop: next_state = mrx_pkg::mrx_st_idle;
      default: next_state = mrx_pkg::mrx_st_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= mrx_pkg::mrx_st_idle;
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      ack <= req & ~ack & ~hold;
      if (req & ~ack) begin
        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // core registers
  // ---------------------------------------------------------------
  // only software writes status; of the instructions only reset touches it, clearing it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc <= mrx_pkg::ACC_RST;
      status <= mrx_pkg::STATUS_RST;
      option_cfg <= mrx_pkg::OPTION_RST;
      soft_reset_flag_n <= mrx_pkg::RI_RST;
      global_irq_enable <= mrx_pkg::GIE_RST;
      pc <= mrx_pkg::PC_RST;
      sp <= 4'h0;
      device_reset_req <= 1'b0;
      last_op <= mrx_pkg::OP_IDLE;
      bad_op <= 1'b0;
    end else begin
      device_reset_req <= do_reset;
      if (exec) begin
        last_op <= op;
        bad_op <= ~known;
      end
      if (do_reset) begin
        // core registers but last_op, and the pointers, return to reset, file and stack contents stay; the flag and last_op record why
        acc <= mrx_pkg::ACC_RST;
        status <= mrx_pkg::STATUS_RST;
        option_cfg <= mrx_pkg::OPTION_RST;
        soft_reset_flag_n <= 1'b0;
        global_irq_enable <= mrx_pkg::GIE_RST;
        pc <= mrx_pkg::PC_RST;
        sp <= 4'h0;
      end else begin
        if (wr_acc) begin
          acc <= avs_writedata[7:0];
        end
        if (wr_status) begin
          status <= avs_writedata[7:0];
        end
        if (exec & is_option) begin
          option_cfg <= acc;
        end
        if (wr_power_control_reg) begin
          soft_reset_flag_n <= avs_writedata[mrx_pkg::POWER_CONTROL_REG_RI_BIT];
        end
        if (exec & is_rti) begin
          global_irq_enable <= 1'b1;
        end else if (wr_irq_control_reg) begin
          global_irq_enable <= avs_writedata[mrx_pkg::IRQ_CONTROL_REG_GIE_BIT];
        end
        if (do_pop) begin
          pc <= stack_top;
          sp <= sp_top;
        end else if (wr_pc) begin
          pc <= pc_merged;
        end else if (exec) begin
          pc <= pc + 15'h0001;
        end
        if (wr_push) begin
          sp <= sp + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // storage arrays
  // ---------------------------------------------------------------
  // circular stack: a pop past empty wraps, no underflow flag is kept
  always_ff @(posedge mclk) begin
    if (wr_push & ~do_reset) begin
      stack_mem[sp] <= avs_writedata[14:0];
    end
    if (file_we_fst | file_we_ist | file_we_bus) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_file) begin
      rd_mux[7:0] = file_mem[bus_target];
    end else if (avs_address == mrx_pkg::REG_INSTR) begin
      rd_mux[13:0] = last_op;
      rd_mux[mrx_pkg::INSTR_BAD_BIT] = bad_op;
    end else if (avs_address == mrx_pkg::REG_ACC) begin
      rd_mux[7:0] = acc;
    end else if (avs_address == mrx_pkg::REG_PTR0) begin
      rd_mux[15:0] = indirect_pointer[0];
    end else if (avs_address == mrx_pkg::REG_PTR1) begin
      rd_mux[15:0] = indirect_pointer[1];
    end else if (avs_address == mrx_pkg::REG_PC) begin
      rd_mux[14:0] = pc;
    end else if (avs_address == mrx_pkg::REG_STATUS) begin
      rd_mux[7:0] = status;
    end else if (avs_address == mrx_pkg::REG_OPTION) begin
      rd_mux[7:0] = option_cfg;
    end else if (avs_address == mrx_pkg::REG_POWER_CONTROL_REG) begin
      rd_mux[mrx_pkg::POWER_CONTROL_REG_RI_BIT] = soft_reset_flag_n;
    end else if (avs_address == mrx_pkg::REG_IRQ_CONTROL_REG) begin
      rd_mux[mrx_pkg::IRQ_CONTROL_REG_GIE_BIT] = global_irq_enable;
    end else if (avs_address == mrx_pkg::REG_STACK) begin
      rd_mux[14:0] = stack_top;
      rd_mux[mrx_pkg::STACK_DEPTH_LSB +: 4] = sp;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_file_store;
    exec & is_fst & ~fst_port |=> file_mem[$past(fst_addr)] == $past(acc);
  endproperty
  a_file_store: assert property (p_file_store)
    else $error("file store did not copy accumulator");
  property p_ist_ea;
    exec & is_ist & (pointer_update_mode == mrx_pkg::MODE_PRE_DEC) |=>
      file_mem[$past(ptr_sel[6:0]) - 7'h01] == $past(acc);
  endproperty
  a_ist_ea: assert property (p_ist_ea)
    else $error("pre-decrement store hit the wrong location");
  property p_post_inc;
    exec & is_ist & (pointer_update_mode == mrx_pkg::MODE_POST_INC) |=>
      indirect_pointer[$past(ist_n)] == $past(ptr_sel) + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("post-increment did not advance the pointer");
  property p_rel_keep;
    exec & is_rel |=> $stable(indirect_pointer[0]) &&
                      $stable(indirect_pointer[1]);
  endproperty
  a_rel_keep: assert property (p_rel_keep)
    else $error("relative store changed a pointer");
  // both increment modes, so the post-increment scenario reaches it
  property p_wrap;
    exec & is_ist & (ptr_sel == 16'hffff) & ~pointer_update_mode[0] |=>
      indirect_pointer[$past(ist_n)] == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap to zero");
  property p_status_hold;
    exec & ~is_reset |=> $stable(status);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("instruction altered status");
  // one wait cycle, then the accumulator lands in the option register
  property p_option;
    instr_wr & is_option & ~ack |=> ~avs_waitrequest ##1
                                    option_cfg == $past(acc);
  endproperty
  a_option: assert property (p_option)
    else $error("option load failed");
  property p_reset;
    do_reset |=> device_reset_req && !soft_reset_flag_n && (pc == 15'h0000);
  endproperty
  a_reset: assert property (p_reset)
    else $error("soft reset did not reset the core");
  property p_rti;
    exec & is_rti |=> global_irq_enable && (pc == $past(stack_top));
  endproperty
  a_rti: assert property (p_rti)
    else $error("interrupt return failed");
  property p_ret_wait;
    instr_wr & is_ret & ~ack & (state == mrx_pkg::mrx_st_idle) |->
      avs_waitrequest[*2] ##1 ~avs_waitrequest;
  endproperty
  a_ret_wait: assert property (p_ret_wait)
    else $error("return did not take two cycles");
  property p_idle;
    exec & is_idle |=> $stable(acc) && $stable(sp) &&
                       (pc == $past(pc) + 15'h0001);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle instruction had a side effect");

endmodule

`default_nettype wire

// >>> mrx_pkg.sv
// Purpose: shared constants for the move/return execution unit
// Assumes: 32-bit avalon-mm register window, 8-bit accumulator core
// Notes:   opcode values are a house encoding shared by the whole core

`default_nettype none

package mrx_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int ACC_W = 8;
  localparam int PTR_W = 16;
  localparam int PC_W = 15;
  localparam int FILE_AW = 7;
  localparam int STACK_AW = 4;
  localparam int OP_W = 14;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [9:0] REG_INSTR = 10'h000;
  localparam logic [9:0] REG_ACC = 10'h004;
  localparam logic [9:0] REG_PTR0 = 10'h008;
  localparam logic [9:0] REG_PTR1 = 10'h00c;
  localparam logic [9:0] REG_PC = 10'h010;
  localparam logic [9:0] REG_STATUS = 10'h014;
  localparam logic [9:0] REG_OPTION = 10'h018;
  localparam logic [9:0] REG_POWER_CONTROL_REG = 10'h01c;
  localparam logic [9:0] REG_IRQ_CONTROL_REG = 10'h020;
  localparam logic [9:0] REG_STACK = 10'h024;
  // file window: bit 9 set, file index in bits 8:2
  localparam int FILE_SEL_BIT = 9;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POWER_CONTROL_REG_RI_BIT = 0;
  localparam int IRQ_CONTROL_REG_GIE_BIT = 7;
  localparam int INSTR_BAD_BIT = 16;
  localparam int STACK_DEPTH_LSB = 16;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic RI_RST = 1'b1;
  localparam logic GIE_RST = 1'b0;

  // ---------------------------------------------------------------
  // opcode encoding
  // ---------------------------------------------------------------
  localparam logic [13:0] OP_IDLE = 14'h0000;
  localparam logic [13:0] OP_RESET = 14'h0001;
  localparam logic [13:0] OP_RET = 14'h0008;
  localparam logic [13:0] OP_RTI = 14'h0009;
  localparam logic [13:0] OP_OPTION = 14'h0062;
  localparam logic [6:0] OP_FST_HI = 7'h01;   // 0080 | f
  localparam logic [10:0] OP_IST_HI = 11'h002; // 0010 | n<<2 | mode
  localparam logic [6:0] OP_REL_HI = 7'h7f;   // 3f80 | n<<6 | k

  // pointer update modes
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  typedef enum logic [1:0] {
    mrx_st_idle = 2'b01,
    mrx_st_pop = 2'b10
  } mrx_state_t;

endpackage

`default_nettype wire

// >>> move_return_instr_exec_tb_top.sv
// Purpose: self-checking bench for the move/return execution unit
// Assumes: avalon-mm master in the bench, full byte enables throughout
// Notes:   the master samples waitrequest and readdata at the rising edge,
//          before the design updates; requests change right after it
`timescale 1ns/1ps
`default_nettype none

module move_return_instr_exec_tb_top;
  logic mclk;
  logic nrst;
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic device_reset_req;
  logic [7:0] option_cfg;
  logic global_irq_enable;
  logic [14:0] pc;
  int errors;
  int checks;
  int waits;
  int pulses;

  mrx_exec u_mrx_exec (
    .mclk(mclk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .device_reset_req(device_reset_req),
    .option_cfg(option_cfg),
    .global_irq_enable(global_irq_enable),
    .pc(pc)
  );

  // ---------------------------------------------------------------
  // clock, pulse monitor, watchdog
  // ---------------------------------------------------------------
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  always @(negedge mclk) begin
    if (device_reset_req === 1'b1) pulses++;
  end

  // about 250 cycles of traffic; generous margin for a stuck waitrequest
  initial begin
    #(25 * 5000);
    errors++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // holds the request until a rising edge sees waitrequest low; data is
  // taken and the request dropped at that same edge
  task automatic bus_op(input logic is_wr, input logic [9:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n >= 20) begin
        errors++;
        give_verdict();
      end
      @(posedge mclk);
    end
    waits = n;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus_op(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_op(1'b0, a, 32'h0, d);
    check(d, exp);
  endtask

  task automatic instr(input logic [13:0] op);
    wr(mrx_pkg::REG_INSTR, {18'h0, op});
  endtask

  // execution lands one edge after the accept edge
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask

  function automatic logic [9:0] fa(input int f);
    return 10'h200 + 10'(f * 4);
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic reset_values();
    check(32'(option_cfg), 32'h0000_00ff);
    check(32'(global_irq_enable), 32'h0);
    check(32'(pc), 32'h0);
    rd_chk(mrx_pkg::REG_POWER_CONTROL_REG, 32'h1);
    rd_chk(mrx_pkg::REG_OPTION, 32'hff);
    wr(10'h100, 32'h5a);
    rd_chk(10'h100, 32'h0);
  endtask

  task automatic file_store();
    wr(mrx_pkg::REG_STATUS, 32'ha5);
    wr(mrx_pkg::REG_ACC, 32'h5a);
    instr(14'h00ff);
    check(32'(waits), 32'h1);
    rd_chk(fa(127), 32'h5a);
    wr(mrx_pkg::REG_ACC, 32'h3c);
    instr(14'h0082);
    rd_chk(fa(2), 32'h3c);
    rd_chk(mrx_pkg::REG_STATUS, 32'ha5);
  endtask

  task automatic ind_store();
    logic [1:0] md [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1};
    logic [15:0] st [6] = '{16'h1234, 16'h1234, 16'h1234, 16'h1234,
                            16'hffff, 16'h0000};
    int ef [6] = '{8'h35, 8'h33, 8'h34, 8'h34, 8'h7f, 8'h7f};
    logic [15:0] af [6] = '{16'h1235, 16'h1233, 16'h1235, 16'h1233,
                            16'h0000, 16'hffff};
    logic [9:0] pr;
    for (int i = 0; i < 6; i++) begin
      pr = (i % 2) ? mrx_pkg::REG_PTR1 : mrx_pkg::REG_PTR0;
      wr(pr, {16'h0, st[i]});
      wr(mrx_pkg::REG_ACC, 32'h10 + 32'(i));
      instr(14'h0010 | 14'((i % 2) << 2) | {12'h0, md[i]});
      rd_chk(fa(ef[i]), 32'h10 + 32'(i));
      rd_chk(pr, {16'h0, af[i]});
    end
    rd_chk(mrx_pkg::REG_STATUS, 32'ha5);
  endtask

  task automatic rel_store();
    wr(mrx_pkg::REG_PTR0, 32'h0140);
    wr(mrx_pkg::REG_ACC, 32'h77);
    instr(14'h3fa0);
    rd_chk(fa(8'h20), 32'h77);
    rd_chk(mrx_pkg::REG_PTR0, 32'h0140);
    wr(mrx_pkg::REG_PTR1, 32'h0200);
    wr(mrx_pkg::REG_ACC, 32'h88);
    instr(14'h3fdf);
    rd_chk(fa(8'h1f), 32'h88);
    rd_chk(mrx_pkg::REG_PTR1, 32'h0200);
  endtask

  task automatic port_redirect();
    wr(mrx_pkg::REG_PTR0, 32'h0045);
    wr(fa(0), 32'h99);
    rd_chk(fa(8'h45), 32'h99);
    wr(mrx_pkg::REG_PTR1, 32'h0050);
    wr(mrx_pkg::REG_ACC, 32'h6b);
    instr(14'h0081);
    rd_chk(fa(8'h50), 32'h6b);
    rd_chk(fa(1), 32'h6b);
  endtask

  task automatic option_load();
    wr(mrx_pkg::REG_ACC, 32'h4f);
    instr(mrx_pkg::OP_OPTION);
    check(32'(waits), 32'h1);
    settle();
    check(32'(option_cfg), 32'h4f);
    rd_chk(mrx_pkg::REG_OPTION, 32'h4f);
  endtask

  task automatic idle_op();
    wr(mrx_pkg::REG_PC, 32'h0100);
    instr(mrx_pkg::OP_IDLE);
    check(32'(waits), 32'h1);
    settle();
    check(32'(pc), 32'h0101);
    rd_chk(mrx_pkg::REG_ACC, 32'h4f);
    check(32'(option_cfg), 32'h4f);
    instr(14'h3000);
    rd_chk(mrx_pkg::REG_INSTR, 32'h0001_3000);
  endtask

  // two pushes, then both returns, with checks in between, to unwind them
  task automatic returns();
    wr(mrx_pkg::REG_IRQ_CONTROL_REG, 32'h0);
    wr(mrx_pkg::REG_STACK, 32'h1abc);
    wr(mrx_pkg::REG_STACK, 32'h0123);
    instr(mrx_pkg::OP_RTI);
    check(32'(waits), 32'h2);
    settle();
    check(32'(pc), 32'h0123);
    check(32'(global_irq_enable), 32'h1);
    rd_chk(mrx_pkg::REG_IRQ_CONTROL_REG, 32'h80);
    instr(mrx_pkg::OP_RET);
    check(32'(waits), 32'h2);
    settle();
    check(32'(pc), 32'h1abc);
    rd_chk(mrx_pkg::REG_STATUS, 32'ha5);
  endtask

  task automatic soft_reset();
    pulses = 0;
    instr(mrx_pkg::OP_RESET);
    settle();
    check(32'(pulses), 32'h1);
    check(32'(option_cfg), 32'hff);
    check(32'(global_irq_enable), 32'h0);
    check(32'(pc), 32'h0);
    rd_chk(mrx_pkg::REG_POWER_CONTROL_REG, 32'h0);
    rd_chk(fa(8'h50), 32'h6b);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    pulses = 0;
    nrst = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    reset_values();
    file_store();
    ind_store();
    rel_store();
    port_redirect();
    option_load();
    idle_op();
    returns();
    soft_reset();
    give_verdict();
  end
endmodule

`default_nettype wire
